// ==== hw/csd_decoder.v ====
`timescale 1ns/1ps
`include "csd_defs.vh"

module csd_decoder #(
  parameter OUT_W = `CSD_OUT_W,
  parameter FRAC_W = `CSD_FRAC_W,
  parameter EST_W = `CSD_EST_W,
  parameter RUN_LEN = `CSD_RUN_LEN,
  parameter SYL_TC_US = `CSD_SYL_TC_US,
  parameter SE_TC_US = `CSD_SE_TC_US,
  parameter REF_RATE_KBPS = `CSD_REF_RATE_KBPS
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire sample_clk_in,
  input wire serial_data_in,
  input wire force_quiet_n_in,
  output reg [OUT_W-1:0] level_out,
  output reg bit_strobe_out,
  output reg decision_bit_out,
  output reg clamp_out,
  output reg quiet_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Derived constants

  function integer csd_log2;
    input integer value;
    integer n;
    begin
      n = 0;
      while ((1 << (n + 1)) <= value)
        n = n + 1;
      csd_log2 = n;
    end
  endfunction

  // [R9] syllabic constant in bits
  localparam integer SYL_TAU_BITS = SYL_TC_US * REF_RATE_KBPS / 1000;
  // [R10] estimate constant in bits
  localparam integer SE_TAU_BITS = SE_TC_US * REF_RATE_KBPS / 1000;
  localparam integer SYL_SHIFT = csd_log2(SYL_TAU_BITS);
  localparam integer SE_SHIFT = csd_log2(SE_TAU_BITS);

  // [R14] minimum step two LSB
  localparam integer MIN_STEP_I = `CSD_MIN_STEP_LSB * (1 << FRAC_W);
  localparam integer MAX_STEP_I = `CSD_MAX_STEP_LSB * (1 << FRAC_W);
  localparam integer CLAMP_I = `CSD_CLAMP_LSB * (1 << FRAC_W);
  localparam [EST_W-1:0] MIN_STEP = MIN_STEP_I[EST_W-1:0];
  localparam [EST_W-1:0] MAX_STEP = MAX_STEP_I[EST_W-1:0];
  // [R12] boost sized so random data settles at 16x minimum step
  localparam integer BOOST_INT = ((`CSD_RATIO_X - 1) * `CSD_MIN_STEP_LSB * (1 << FRAC_W) * 4)
                                 / SYL_TAU_BITS;
  localparam [EST_W-1:0] BOOST = BOOST_INT[EST_W-1:0];
  // [R7] clamp limit in accumulator units
  localparam [EST_W-1:0] CLAMP_ACC = CLAMP_I[EST_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Three equal bits in the window grow the step
  function csd_run;
    input [RUN_LEN-1:0] bits;
    begin
      csd_run = (&bits) | (~|bits);
    end
  endfunction

  // True once a signed sum reaches the clamp in either polarity
  function csd_at_limit;
    input [EST_W-1:0] sum;
    input [EST_W-1:0] limit;
    begin
      csd_at_limit = ($signed(sum) >= $signed(limit)) || ($signed(sum) <= -$signed(limit));
    end
  endfunction

  // Saturate a signed sum to the clamp in either polarity
  function [EST_W-1:0] csd_sat;
    input [EST_W-1:0] sum;
    input [EST_W-1:0] limit;
    begin
      if ($signed(sum) >= $signed(limit))
        csd_sat = limit;
      else if ($signed(sum) <= -$signed(limit))
        csd_sat = {EST_W{1'b0}} - limit;
      else
        csd_sat = sum;
    end
  endfunction

  // Whole output LSB of a fixed point estimate
  function [OUT_W-1:0] csd_level;
    input [EST_W-1:0] acc;
    begin
      csd_level = acc[FRAC_W+OUT_W-1:FRAC_W];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  reg sclk_q;
  reg quiet_phase_q;
  reg [RUN_LEN-2:0] hist_q;
  reg [EST_W-1:0] step_q;
  reg signed [EST_W-1:0] est_q;

  // Next values
  reg phase_d;
  reg [RUN_LEN-2:0] hist_d;
  reg [EST_W-1:0] step_d;
  reg signed [EST_W-1:0] est_d;
  reg [OUT_W-1:0] level_d;
  reg strobe_d;
  reg decision_d;
  reg clamp_d;
  reg quiet_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Sampling clock edges

  // [R15] rate free detection; reset copies the pin so no false edge follows
  always @(posedge ref_clk_in) begin
    if (rst_in)
      sclk_q <= sample_clk_in;
    else
      sclk_q <= sample_clk_in;
  end

  // [R1] one bit per rise
  wire rise = sample_clk_in & ~sclk_q;
  wire fall = ~sample_clk_in & sclk_q;
  // [R4] rising edge takes bit
  wire take = rise & force_quiet_n_in;
  // [R5] quiet while low
  wire quiet_mode = ~force_quiet_n_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Run detector and syllabic filter

  reg [RUN_LEN-1:0] window;
  reg run_hit;
  reg [EST_W-1:0] step_decay;
  reg [EST_W-1:0] step_sum;
  reg [EST_W-1:0] step_calc;

  always @* begin
    window = {hist_q, serial_data_in};
    // [R16] run of equal bits
    run_hit = csd_run(window);
    // [R11] one-pole decay toward minimum
    step_decay = (step_q - MIN_STEP) >> SYL_SHIFT;
    step_sum = step_q - step_decay;
    if (run_hit)
      step_sum = step_sum + BOOST;
    // [R12] step capped at maximum
    if (step_sum > MAX_STEP)
      step_calc = MAX_STEP;
    else
      step_calc = step_sum;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Signal estimate filter and clamp

  reg signed [EST_W-1:0] est_leak;
  reg signed [EST_W-1:0] est_sum;
  reg signed [EST_W-1:0] est_calc;
  reg clamp_calc;

  always @* begin
    // [R11] leaky estimate integrator
    est_leak = est_q >>> SE_SHIFT;
    est_sum = est_q - est_leak;
    // [R16] old step added by polarity
    if (serial_data_in)
      est_sum = est_sum + $signed(step_q);
    else
      est_sum = est_sum - $signed(step_q);
    // [R7] clamp at three quarters
    clamp_calc = csd_at_limit(est_sum, CLAMP_ACC);
    est_calc = csd_sat(est_sum, CLAMP_ACC);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always @* begin
    phase_d = quiet_phase_q;
    hist_d = hist_q;
    step_d = step_q;
    est_d = est_q;
    level_d = level_out;
    strobe_d = 1'b0;
    decision_d = decision_bit_out;
    clamp_d = clamp_out;
    quiet_d = quiet_out;
    if (quiet_mode) begin
      // [R5] hold all logic reset
      hist_d = {(RUN_LEN-1){1'b0}};
      step_d = MIN_STEP;
      est_d = {EST_W{1'b0}};
      decision_d = 1'b0;
      clamp_d = 1'b0;
      quiet_d = 1'b1;
      // [R6] toggle on falling edge
      if (fall) begin
        phase_d = ~quiet_phase_q;
        level_d = quiet_phase_q ? `CSD_QUIET_LO : `CSD_QUIET_HI;
      end
    end else if (take) begin
      // [R4] capture decision bit
      quiet_d = 1'b0;
      phase_d = 1'b0;
      decision_d = serial_data_in;
      hist_d = window[RUN_LEN-2:0];
      strobe_d = 1'b1;
      // [R8] one filter update per bit
      est_d = est_calc;
      // [R7] step frozen while clamped
      if (!clamp_out)
        step_d = step_calc;
      clamp_d = clamp_calc;
      // [R13] quantize to output LSB
      level_d = csd_level(est_calc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // [R6] quiet pattern phase
  always @(posedge ref_clk_in) begin
    if (rst_in)
      quiet_phase_q <= 1'b0;
    else
      quiet_phase_q <= phase_d;
  end

  // [R16] bit history
  always @(posedge ref_clk_in) begin
    if (rst_in)
      hist_q <= {(RUN_LEN-1){1'b0}};
    else
      hist_q <= hist_d;
  end

  // Step starts at minimum
  always @(posedge ref_clk_in) begin
    if (rst_in)
      step_q <= MIN_STEP;
    else
      step_q <= step_d;
  end

  // Estimate accumulator
  always @(posedge ref_clk_in) begin
    if (rst_in)
      est_q <= {EST_W{1'b0}};
    else
      est_q <= est_d;
  end

  // Registered output level
  always @(posedge ref_clk_in) begin
    if (rst_in)
      level_out <= `CSD_QUIET_LO;
    else
      level_out <= level_d;
  end

  // One-cycle bit strobe
  always @(posedge ref_clk_in) begin
    if (rst_in)
      bit_strobe_out <= 1'b0;
    else
      bit_strobe_out <= strobe_d;
  end

  // [R4] decision held until next bit
  always @(posedge ref_clk_in) begin
    if (rst_in)
      decision_bit_out <= 1'b0;
    else
      decision_bit_out <= decision_d;
  end

  // [R7] clamp flag
  always @(posedge ref_clk_in) begin
    if (rst_in)
      clamp_out <= 1'b0;
    else
      clamp_out <= clamp_d;
  end

  // [R5] quiet flag
  always @(posedge ref_clk_in) begin
    if (rst_in)
      quiet_out <= 1'b1;
    else
      quiet_out <= quiet_d;
  end

endmodule // csd_decoder

// ==== hw/csd_defs.vh ====
// Contract
// [R1] One serial data bit per sampling clock period; bit rate equals clock rate.
// [R2] Source places the rising sampling edge in the middle of each bit.
// [R3] Source changes the serial bit only on falling sampling edges.
// [R4] Decoder captures the serial bit on each rising sampling edge as the decision.
// [R5] Force-quiet low resets all decoder logic and forces the idle quieting output.
// [R6] Quieting output toggles between two adjacent levels on falling edges, half rate.
// [R7] Estimate clamps at three quarters of full scale; releases once below it.
// [R8] Filters update once per bit, so time constants scale inversely with rate.
// [R9] Syllabic filter time constant about 4.0 ms at 16 kbps.
// [R10] Signal-estimate filter time constant about 1.0 ms at the reference rate.
// [R11] Both filters are single-pole first-order recursive filters.
// [R12] Syllabic output at equal ones/zeros density about 24 dB above its minimum.
// [R13] Estimate quantized with smallest level about 0.1 percent of full scale.
// [R14] Minimum step is twice the resolution, about 0.2 percent.
// [R15] Works from 9 to 64 kbps and beyond either limit.
// [R16] Runs of equal bits grow the step, else it decays; bits add or subtract it.
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

// Output resolution and fixed point
`define CSD_OUT_W 10
`define CSD_FRAC_W 8
`define CSD_EST_W 20
// Reference rate and filter time constants
`define CSD_REF_RATE_KBPS 16
`define CSD_SYL_TC_US 4000
`define CSD_SE_TC_US 1000
// Step sizes in output LSB
`define CSD_MIN_STEP_LSB 2
`define CSD_MAX_STEP_LSB 128
`define CSD_RATIO_X 16
`define CSD_RUN_LEN 3
// Clamp at 0.75 of a half scale of 512 LSB
`define CSD_CLAMP_LSB 384
// Quieting levels
`define CSD_QUIET_LO 10'h000
`define CSD_QUIET_HI 10'h001

`endif

// ==== testbench/csd_decoder_sva.sv ====
`timescale 1ns/1ps
module csd_decoder_sva (
  input wire ref_clk_in,
  input wire rst_in,
  input wire sample_clk_in,
  input wire serial_data_in,
  input wire force_quiet_n_in,
  input wire [9:0] level_out,
  input wire bit_strobe_out,
  input wire decision_bit_out,
  input wire clamp_out,
  input wire quiet_out
);
  reg prev_q;
  wire take = sample_clk_in & ~prev_q & force_quiet_n_in;
  wire fall = prev_q & ~sample_clk_in;
  always @(posedge ref_clk_in) prev_q <= sample_clk_in;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  strobe_take_a: assert property (take |=> bit_strobe_out && !quiet_out)
    else $error("bit not taken");
  strobe_cause_a: assert property (bit_strobe_out |-> $past(take))
    else $error("stray strobe");
  decision_bit_a: assert property (take |=> decision_bit_out == $past(serial_data_in))
    else $error("wrong decision");
  quiet_hold_a: assert property (!force_quiet_n_in |=> quiet_out && !bit_strobe_out)
    else $error("quiet not held");
  quiet_toggle_a: assert property (!force_quiet_n_in && !$past(force_quiet_n_in) && fall
    |=> level_out < 10'h002 && (level_out != $past(level_out) || $past(level_out) >= 10'h002))
    else $error("no toggle");
  quiet_still_a: assert property (!force_quiet_n_in && !$past(force_quiet_n_in) && !fall
    |=> $stable(level_out)) else $error("quiet moved");
  idle_hold_a: assert property (force_quiet_n_in && $past(force_quiet_n_in) && !take
    |=> $stable(level_out)) else $error("level moved");
  clamp_level_a: assert property (clamp_out |-> level_out == 10'h180 || level_out == 10'h280)
    else $error("clamp level");
  cover property (take && serial_data_in);
  cover property (clamp_out);
  cover property (fall && !force_quiet_n_in);
endmodule // csd_decoder_sva
bind csd_decoder csd_decoder_sva csd_decoder_sva_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .sample_clk_in(sample_clk_in), .serial_data_in(serial_data_in), .level_out(level_out),
  .force_quiet_n_in(force_quiet_n_in), .bit_strobe_out(bit_strobe_out), .quiet_out(quiet_out),
  .decision_bit_out(decision_bit_out), .clamp_out(clamp_out));

// ==== testbench/csd_decoder_tb_top.sv ====
`timescale 1ns/1ps
module csd_decoder_tb_top;
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg force_quiet_n_in = 1'b1;
  wire sample_clk_in, serial_data_in, bit_strobe_out, decision_bit_out, clamp_out, quiet_out;
  wire [9:0] level_out;
  integer errors = 0, checked = 0, cycles = 0, i;
  reg [10:0] rows [0:5];
  initial forever #2 ref_clk_in = ~ref_clk_in;
  csd_decoder csd_decoder_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .sample_clk_in(sample_clk_in), .serial_data_in(serial_data_in), .level_out(level_out),
    .force_quiet_n_in(force_quiet_n_in), .bit_strobe_out(bit_strobe_out), .quiet_out(quiet_out),
    .decision_bit_out(decision_bit_out), .clamp_out(clamp_out));
  csd_src_model csd_src_model_inst (.ref_clk_in(ref_clk_in), .sample_clk_out(sample_clk_in),
    .serial_data_out(serial_data_in));
  task check(input [12:0] seen, input [12:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        errors = errors + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  initial begin
    rows[0] = 11'h402;
    rows[1] = 11'h3ff;
    rows[2] = 11'h401;
    rows[3] = 11'h403;
    rows[4] = 11'h001;
    rows[5] = 11'h3ff;
    repeat (20) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    check({quiet_out, clamp_out, bit_strobe_out, level_out}, 13'h1000);
    for (i = 0; i < 6; i = i + 1) begin
      csd_src_model_inst.send(rows[i][10]);
      @(posedge ref_clk_in);
      #1 check({1'b0, quiet_out, decision_bit_out, level_out}, {2'b00, rows[i]});
    end
    repeat (60) csd_src_model_inst.send(1'b1);
    #1 check({2'b00, clamp_out, level_out}, 13'h0580);
    repeat (60) csd_src_model_inst.send(1'b0);
    #1 check({2'b00, clamp_out, level_out}, 13'h0680);
    csd_src_model_inst.send(1'b1);
    #1 check({12'h000, clamp_out}, 13'h0000);
    @(posedge ref_clk_in);
    #1 force_quiet_n_in = 1'b0;
    csd_src_model_inst.send(1'b1);
    #1 check({2'b00, quiet_out, level_out}, 13'h0401);
    csd_src_model_inst.send(1'b1);
    #1 check({2'b00, quiet_out, level_out}, 13'h0400);
    @(posedge ref_clk_in);
    #1 force_quiet_n_in = 1'b1;
    csd_src_model_inst.send(1'b1);
    #1 check({2'b00, quiet_out, level_out}, 13'h0002);
    @(posedge ref_clk_in);
    #1 rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    check({quiet_out, clamp_out, bit_strobe_out, level_out}, 13'h1000);
    @(posedge ref_clk_in);
    #1 check({quiet_out, clamp_out, bit_strobe_out, level_out}, 13'h1000);
    csd_src_model_inst.half_cycles = 1;
    csd_src_model_inst.send(1'b0);
    @(posedge ref_clk_in);
    #1 check({quiet_out, bit_strobe_out, decision_bit_out, level_out}, 13'h0bfe);
    csd_src_model_inst.send(1'b0);
    @(posedge ref_clk_in);
    #1 check({quiet_out, bit_strobe_out, decision_bit_out, level_out}, 13'h0bfa);
    complete_run;
  end
endmodule // csd_decoder_tb_top

// ==== testbench/csd_src_model.sv ====
`timescale 1ns/1ps
module csd_src_model #(parameter HALF = 4) (
  input wire ref_clk_in,
  output reg sample_clk_out = 1'b0,
  output reg serial_data_out = 1'b0
);
  integer half_cycles = HALF;
  // data moves on the fall, rise mid-bit
  task send(input reg b);
    begin
      @(posedge ref_clk_in);
      #1 sample_clk_out = 1'b0;
      serial_data_out = b;
      repeat (half_cycles) @(posedge ref_clk_in);
      #1 sample_clk_out = 1'b1;
      repeat (half_cycles - 1) @(posedge ref_clk_in);
    end
  endtask
endmodule // csd_src_model
